// [include/dmact_defines.svh]
`ifndef DMACT_DEFINES_SVH
`define DMACT_DEFINES_SVH
// per-channel register offsets inside one 32-byte window
`define DMACT_OFF_CSR 5'h00
`define DMACT_OFF_CNT 5'h04
`define DMACT_OFF_SRC 5'h08
`define DMACT_OFF_TRIG 5'h10
// channel window y sits at y * 32, y = 1..5
`define DMACT_CH_FIRST 3'h1
`define DMACT_CH_LAST 3'h5
// interrupt status and mask
`define DMACT_OFF_ISTAT 8'hC0
`define DMACT_OFF_IMASK 8'hC4
// trigger register fields
`define DMACT_TRIG_MODE_BIT 0
`define DMACT_TRIG_SW_BIT 1
`define DMACT_TRIG_SEL_LO 2
`define DMACT_TRIG_SEL_HI 7
`define DMACT_HW_SEL_MAX 6'h2A
`define DMACT_HW_EVENTS 43
// count register fields
`define DMACT_CNT_HI 15
`define DMACT_REP_LO 16
`define DMACT_REP_HI 19
// control and status layout width
`define DMACT_CSR_HI 10
// channel state codes
`define DMACT_ST_INIT 3'h0
`define DMACT_ST_RANGE 3'h1
`define DMACT_ST_STOP 3'h2
`define DMACT_ST_SRCERR 3'h3
`define DMACT_ST_DSTERR 3'h4
`define DMACT_ST_DONE 3'h5
// unit width codes
`define DMACT_SZ_8 2'h0
`define DMACT_SZ_16 2'h1
`define DMACT_SZ_32 2'h2
// zero reset value
`define DMACT_RST32 32'h0000_0000
`endif

// [include/dmact_pkg.sv]
package dmact_pkg;
  // control and status word, bits 10:0
  typedef struct packed {
    logic [2:0] status;
    logic [1:0] size;
    logic dstinc;
    logic source_increment;
    logic blk;
    logic teie;
    logic tcie;
    logic en;
  } dmact_csr_t;
  // trigger word, bits 7:0
  typedef struct packed {
    logic [5:0] hw_sel;
    logic sw;
    logic hw_mode;
  } dmact_trig_t;
  // source fetch request towards the on-chip bus
  typedef struct packed {
    logic [31:0] addr;
    logic [1:0] size;
    logic [2:0] ch;
  } dmact_rdreq_t;
  typedef enum logic [2:0] {
    DMACT_R_CSR, DMACT_R_CNT, DMACT_R_SRC, DMACT_R_TRIG,
    DMACT_R_ISTAT, DMACT_R_IMASK
  } dmact_reg_t;
  typedef struct packed {
    logic ok;
    logic [2:0] ch;
    dmact_reg_t kind;
  } dmact_dec_t;
  typedef enum logic {DMACT_IDLE, DMACT_BUSY} dmact_state_t;
endpackage

// [rtl/dmact_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dmact_defines.svh"
module dmact_top
  import dmact_pkg::*;
#(
  parameter int NCH = 5,
  parameter int AW = 8
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [`DMACT_HW_EVENTS-1:0] hw_evt,
  output dmact_rdreq_t rd_req,
  output logic rd_req_valid,
  input wire logic rd_ack,
  input wire logic rd_err,
  input wire logic [31:0] rd_data,
  output logic [31:0] unit_data,
  output logic [2:0] unit_ch,
  output logic unit_valid
);

  // address decode, interrupt words then channel windows
  function automatic dmact_dec_t decode(input logic [AW-1:0] a);
    dmact_dec_t d;
    d = '{ok: 1'b0, ch: 3'h0, kind: DMACT_R_CSR};
    if (a == `DMACT_OFF_ISTAT)
    begin
      d.ok = 1'b1;
      d.kind = DMACT_R_ISTAT;
    end
    else if (a == `DMACT_OFF_IMASK)
    begin
      d.ok = 1'b1;
      d.kind = DMACT_R_IMASK;
    end
    else if (a[7:5] >= `DMACT_CH_FIRST && a[7:5] <= `DMACT_CH_LAST)
    begin
      d.ch = a[7:5] - `DMACT_CH_FIRST;
      d.ok = 1'b1;
      if (a[4:0] == `DMACT_OFF_CSR)
        d.kind = DMACT_R_CSR;
      else if (a[4:0] == `DMACT_OFF_CNT)
        d.kind = DMACT_R_CNT;
      else if (a[4:0] == `DMACT_OFF_SRC)
        d.kind = DMACT_R_SRC;
      else if (a[4:0] == `DMACT_OFF_TRIG)
        d.kind = DMACT_R_TRIG;
      else
        d.ok = 1'b0;
    end
    return d;
  endfunction

  // address step per unit from the width code
  function automatic logic [31:0] step(input logic [1:0] sz);
    if (sz == `DMACT_SZ_8)
      return 32'h0000_0001;
    else if (sz == `DMACT_SZ_16)
      return 32'h0000_0002;
    else
      return 32'h0000_0004;
  endfunction

  // selected event flag; codes past the table never fire
  function automatic logic hw_pick(
    input logic [`DMACT_HW_EVENTS-1:0] ev,
    input logic [5:0] sel
  );
    return (sel <= `DMACT_HW_SEL_MAX) ? ev[sel] : 1'b0;
  endfunction

  dmact_dec_t dec; // decode of the held address
  logic wr_en; // write takes effect this edge
  logic [31:0] rdata_nxt; // read mux output
  dmact_csr_t csr_r [NCH]; // per-channel control and state
  logic [15:0] cnt_r [NCH]; // units still remaining
  logic [3:0] rep_r [NCH]; // repeat field, stored only
  logic [31:0] src_r [NCH]; // current source address
  dmact_trig_t trig_r [NCH]; // trigger config, sw bit unused
  logic busy_r [NCH]; // transfer in progress
  wire logic [NCH-1:0] done_ev; // completion pulse
  wire logic [NCH-1:0] err_ev; // error or abort pulse
  wire logic [NCH-1:0] elig; // channel ready for a fetch
  logic [2:0] pick; // lowest eligible channel
  dmact_state_t st_r; // fetch engine state
  logic [2:0] cur_r; // channel being served
  logic [2*NCH-1:0] istat_r; // sticky events
  logic [2*NCH-1:0] imask_r; // interrupt mask
  logic [2*NCH-1:0] istat_nxt;

  assign dec = decode(paddr);
  assign wr_en = psel && penable && pready && pwrite && dec.ok;

  // apb handshake: one wait-free access phase after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `DMACT_RST32;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !dec.ok; // unmapped answers error
      if (psel && !penable)
        prdata <= rdata_nxt;
    end
  end

  // read mux; reserved bits read zero
  always_comb
  begin
    rdata_nxt = `DMACT_RST32;
    if (dec.ok)
    begin
      case (dec.kind)
        DMACT_R_CSR: rdata_nxt = {21'h0, csr_r[dec.ch]};
        DMACT_R_CNT: rdata_nxt = {12'h0, rep_r[dec.ch], cnt_r[dec.ch]};
        DMACT_R_SRC: rdata_nxt = src_r[dec.ch];
        DMACT_R_TRIG: rdata_nxt = {24'h0, trig_r[dec.ch].hw_sel,
                                   busy_r[dec.ch],
                                   trig_r[dec.ch].hw_mode};
        DMACT_R_ISTAT: rdata_nxt = {{(32-2*NCH){1'b0}}, istat_r};
        DMACT_R_IMASK: rdata_nxt = {{(32-2*NCH){1'b0}}, imask_r};
        default: rdata_nxt = `DMACT_RST32;
      endcase
    end
  end

  // per-channel registers and sequencing
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    logic wr_csr, wr_cnt, wr_src, wr_trig; // software writes per word
    logic served, got, bad; // engine on us, unit in, fetch failed
    logic sw_fire, hw_fire; // start requests
    logic fin, stop; // normal end and abort
    assign wr_csr = wr_en && dec.ch == 3'(c) && dec.kind == DMACT_R_CSR;
    assign wr_cnt = wr_en && dec.ch == 3'(c) && dec.kind == DMACT_R_CNT;
    assign wr_src = wr_en && dec.ch == 3'(c) && dec.kind == DMACT_R_SRC;
    assign wr_trig = wr_en && dec.ch == 3'(c) && dec.kind == DMACT_R_TRIG;
    assign served = st_r == DMACT_BUSY && cur_r == 3'(c);
    assign got = served && rd_ack;
    assign bad = served && !rd_ack && rd_err;
    // software start works in either mode; writing zero does nothing
    assign sw_fire = wr_trig && pwdata[`DMACT_TRIG_SW_BIT] &&
                     csr_r[c].en;
    // hardware start only in hardware mode and when enabled
    assign hw_fire = csr_r[c].en && trig_r[c].hw_mode &&
                     hw_pick(hw_evt, trig_r[c].hw_sel);
    // end when nothing is left and no fetch is outstanding
    assign fin = busy_r[c] && cnt_r[c] == 16'h0000 && !served;
    // disable while running stops the channel
    assign stop = busy_r[c] && !csr_r[c].en && !served && !fin;
    assign done_ev[c] = fin;
    assign err_ev[c] = bad || stop;
    assign elig[c] = busy_r[c] && csr_r[c].en && cnt_r[c] != 16'h0000;

    // busy flag behind the software trigger bit
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        busy_r[c] <= 1'b0;
      else if (!busy_r[c] && (sw_fire || hw_fire))
        busy_r[c] <= 1'b1;
      else if (fin || stop || bad)
        busy_r[c] <= 1'b0;
    end

    // control word; hardware state update beats a software write
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        csr_r[c] <= '0;
      else
      begin
        if (wr_csr)
          csr_r[c] <= pwdata[`DMACT_CSR_HI:0];
        if (fin)
          csr_r[c].status <= `DMACT_ST_DONE;
        else if (bad)
          csr_r[c].status <= `DMACT_ST_SRCERR;
        else if (stop)
          csr_r[c].status <= `DMACT_ST_STOP;
      end
    end

    // count; a unit finishing wins over a software write
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        cnt_r[c] <= 16'h0000;
        rep_r[c] <= 4'h0;
      end
      else
      begin
        if (wr_cnt)
        begin
          cnt_r[c] <= pwdata[`DMACT_CNT_HI:0];
          rep_r[c] <= pwdata[`DMACT_REP_HI:`DMACT_REP_LO];
        end
        if (got)
          cnt_r[c] <= cnt_r[c] - 16'h0001;
      end
    end

    // source address, advanced by the unit width when enabled
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        src_r[c] <= `DMACT_RST32;
      else if (got && csr_r[c].source_increment)
        src_r[c] <= src_r[c] + step(csr_r[c].size);
      else if (wr_src)
        src_r[c] <= pwdata;
    end

    // trigger configuration; the sw bit is not stored
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        trig_r[c] <= '0;
      else if (wr_trig)
      begin
        trig_r[c].hw_sel <= pwdata[`DMACT_TRIG_SEL_HI:`DMACT_TRIG_SEL_LO];
        trig_r[c].hw_mode <= pwdata[`DMACT_TRIG_MODE_BIT];
      end
    end
  end

  // fixed priority, lowest channel first; simple but can starve
  always_comb
  begin
    pick = 3'h0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (elig[i])
        pick = 3'(i);
    end
  end

  // fetch engine: one outstanding read at a time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= DMACT_IDLE;
      cur_r <= 3'h0;
      rd_req_valid <= 1'b0;
      rd_req <= '0;
    end
    else
    begin
      case (st_r)
        DMACT_IDLE:
        begin
          if (|elig)
          begin
            st_r <= DMACT_BUSY;
            cur_r <= pick;
            rd_req_valid <= 1'b1;
            rd_req.addr <= src_r[pick];
            rd_req.size <= csr_r[pick].size;
            rd_req.ch <= pick;
          end
        end
        DMACT_BUSY:
        begin
          if (rd_ack || rd_err)
          begin
            st_r <= DMACT_IDLE;
            rd_req_valid <= 1'b0;
          end
        end
        default: st_r <= DMACT_IDLE;
      endcase
    end
  end

  // fetched unit handed on, one-cycle valid
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unit_valid <= 1'b0;
      unit_data <= `DMACT_RST32;
      unit_ch <= 3'h0;
    end
    else
    begin
      unit_valid <= st_r == DMACT_BUSY && rd_ack;
      if (st_r == DMACT_BUSY && rd_ack)
      begin
        unit_data <= rd_data;
        unit_ch <= cur_r;
      end
    end
  end

  // sticky events: done in low half, error in high; set beats clear
  always_comb
  begin
    istat_nxt = istat_r;
    if (wr_en && dec.kind == DMACT_R_ISTAT)
      istat_nxt = istat_r & ~pwdata[2*NCH-1:0];
    istat_nxt = istat_nxt | {err_ev, done_ev};
  end

  // status, mask and the level interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      istat_r <= '0;
      imask_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      istat_r <= istat_nxt;
      if (wr_en && dec.kind == DMACT_R_IMASK)
        imask_r <= pwdata[2*NCH-1:0];
      irq <= |(istat_nxt & imask_r);
    end
  end

endmodule
`default_nettype wire

// [sim/dmact_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module dmact_props
  import dmact_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire dmact_rdreq_t rd_req,
  input wire logic rd_req_valid,
  input wire logic rd_ack,
  input wire logic rd_err,
  input wire logic [31:0] rd_data,
  input wire logic [31:0] unit_data,
  input wire logic [2:0] unit_ch,
  input wire logic unit_valid
);
  logic ack_d_r; // a unit was taken one cycle ago
  // helper: remembers the fetch that a unit must follow
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ack_d_r <= 1'b0;
    else
      ack_d_r <= rd_req_valid & rd_ack;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence fetch_s; rd_req_valid && rd_ack; endsequence
  sequence pend_s; rd_req_valid && !rd_ack && !rd_err; endsequence
  ready_first_a: assert property (
    psel && penable && !$past(penable) |-> pready)
    else $error("pready missing in first access cycle");
  ready_once_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  unmapped_zero_a: assert property (
    pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("unmapped access answered wrongly");
  req_hold_a: assert property (
    pend_s |=> rd_req_valid && $stable(rd_req))
    else $error("fetch request changed while pending");
  req_drop_a: assert property (
    rd_req_valid && (rd_ack || rd_err) |=> !rd_req_valid)
    else $error("fetch request not released");
  unit_data_a: assert property (fetch_s |=> unit_valid &&
    unit_data == $past(rd_data) && unit_ch == $past(rd_req.ch))
    else $error("unit does not carry fetched word");
  unit_cause_a: assert property (
    unit_valid |-> ack_d_r && !$past(unit_valid))
    else $error("unit without a fetch");
  // channel field counts from zero: channel one is index 0
  req_shape_a: assert property (
    rd_req_valid |-> rd_req.size != 2'h3 && rd_req.ch inside {[0:4]})
    else $error("bad unit width or channel");
endmodule
bind dmact_top dmact_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rd_req(rd_req),
  .rd_req_valid(rd_req_valid), .rd_ack(rd_ack), .rd_err(rd_err),
  .rd_data(rd_data), .unit_data(unit_data), .unit_ch(unit_ch),
  .unit_valid(unit_valid));
`default_nettype wire

// [sim/dmact_src_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module dmact_src_mem
  import dmact_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire dmact_rdreq_t rd_req,
  input wire logic rd_req_valid,
  input wire logic slow,
  input wire logic err_en,
  input wire logic [31:0] err_addr,
  output logic rd_ack,
  output logic rd_err,
  output logic [31:0] rd_data
);
  int wait_r; // cycles left before the next answer
  // one answer per request; slow mode leaves room to read mid-run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_r <= 0;
      rd_ack <= 1'b0;
      rd_err <= 1'b0;
      rd_data <= 32'h0;
    end
    else
    begin
      rd_ack <= 1'b0;
      rd_err <= 1'b0;
      rd_data <= ~rd_data; // idle data flips each cycle, so it differs from the last word in the next cycle
      if (rd_req_valid && !rd_ack && !rd_err && wait_r > 0)
        wait_r <= wait_r - 1;
      else if (rd_req_valid && !rd_ack && !rd_err)
      begin
        wait_r <= slow ? 20 : int'($urandom_range(3));
        if (err_en && rd_req.addr == err_addr)
          rd_err <= 1'b1; // faulting location
        else
        begin
          rd_ack <= 1'b1;
          rd_data <= {rd_req.addr[15:0], rd_req.addr[31:16]} ^
                     32'hC3C3_3C3C;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [sim/dma_channel_trigger_count_source_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dmact_defines.svh"
module dma_channel_trigger_count_source_bench
  import dmact_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, slow = 1'b0, err_en = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, err_addr = 32'h0, prdata, rd_data, unit_data;
  logic [`DMACT_HW_EVENTS-1:0] hw_evt = '0; // peripheral flags
  logic pready, pslverr, irq, rd_req_valid, rd_ack, rd_err, unit_valid;
  logic [2:0] unit_ch;
  dmact_rdreq_t rd_req;
  logic [31:0] rq, src, csr; // last read word, scenario values
  logic rerr, inc;
  logic [1:0] sz;
  logic [34:0] ex, exp_q[$]; // expected {channel, word} per unit
  int err_total = 0, n_checks = 0, cyc = 0, n, k;
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); \
      err_total++; \
    end \
  end
  always #20 pclk = ~pclk;
  dmact_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .hw_evt(hw_evt), .rd_req(rd_req), .rd_req_valid(rd_req_valid),
    .rd_ack(rd_ack), .rd_err(rd_err), .rd_data(rd_data),
    .unit_data(unit_data), .unit_ch(unit_ch), .unit_valid(unit_valid));
  dmact_src_mem mem (.pclk(pclk), .presetn(presetn), .rd_req(rd_req),
    .rd_req_valid(rd_req_valid), .slow(slow), .err_en(err_en),
    .err_addr(err_addr), .rd_ack(rd_ack), .rd_err(rd_err),
    .rd_data(rd_data));
  // expected word, written apart from the memory model
  function automatic logic [31:0] memv(input logic [31:0] a);
    return {a[15:0], a[31:16]} ^ 32'hC3C3_3C3C;
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one APB transfer; an idle cycle follows so no strobe is set twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rq = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rq, e)
  endtask
  // hang guard, far above the expected run length
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end
  // every unit is compared with the model queue; stray units fail
  always @(posedge pclk)
    if (unit_valid === 1'b1)
    begin
      ex = (exp_q.size() > 0) ? exp_q.pop_front() : 35'h0;
      `CHK({unit_ch, unit_data}, ex)
    end
  initial
  begin
    k = $urandom(32'hEA0A);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int c = 1; c <= 5; c++)
      for (int o = 0; o <= 16; o += 4)
        if (o != 12)
          rd(8'(c * 32 + o), 32'h0);
    rd(8'hE0, 32'h0);
    `CHK(rerr, 1'b1)
    $display("test reset done");
    slow <= 1'b1;
    for (int c = 1; c <= 5; c++)
    begin
      sz = 2'($urandom_range(2));
      inc = 1'($urandom_range(1));
      n = 3 + $urandom_range(3);
      src = 32'h2000_0000 + ($urandom & 32'hFFF0); // plain RAM
      csr = {24'h0, sz, 1'b0, inc, 4'h1};
      apb(1'b1, 8'(c * 32), csr);
      apb(1'b1, 8'(c * 32 + 4), 32'h0001_0000 | 32'(n));
      apb(1'b1, 8'(c * 32 + 8), src);
      rd(8'(c * 32 + 8), src);
      for (int i = 0; i < n; i++)
        exp_q.push_back({3'(c - 1),
                         memv(src + (inc ? 32'(i) << sz : 0))});
      apb(1'b1, 8'(c * 32 + 16), 32'h2);
      while (exp_q.size() >= n)
        @(posedge pclk);
      rd(8'(c * 32 + 4), 32'h0001_0000 | 32'(n - 1));
      rd(8'(c * 32 + 16), 32'h2);
      while (exp_q.size() > 0)
        @(posedge pclk);
      repeat (3) @(posedge pclk);
      rd(8'(c * 32 + 16), 32'h0);
      rd(8'(c * 32 + 4), 32'h0001_0000);
      rd(8'(c * 32), csr | 32'h500);
    end
    $display("test software trigger done");
    slow <= 1'b0;
    for (int c = 1; c <= 5; c++)
      apb(1'b1, 8'(c * 32), 32'h81);
    for (int s = 0; s < 43; s++)
    begin
      k = 1 + s % 5;
      apb(1'b1, 8'(k * 32 + 4), 32'h0001_0001);
      apb(1'b1, 8'(k * 32 + 8), 32'h2000_0000 + 32'(s * 4));
      apb(1'b1, 8'(k * 32 + 16), 32'(s * 4 + 1));
      hw_evt[(s + 1) % 43] <= 1'b1; // other flag must not start it
      @(posedge pclk);
      hw_evt <= '0;
      repeat (6) @(posedge pclk);
      exp_q.push_back({3'(k - 1), memv(32'h2000_0000 + 32'(s * 4))});
      hw_evt[s] <= 1'b1;
      @(posedge pclk);
      hw_evt <= '0;
      while (exp_q.size() > 0)
        @(posedge pclk);
      repeat (3) @(posedge pclk);
    end
    $display("test hardware trigger done");
    apb(1'b1, 8'hC0, 32'h3FF);
    apb(1'b1, 8'h20, 32'h0);
    apb(1'b1, 8'h30, 32'h3);
    apb(1'b1, 8'h50, 32'hC);
    hw_evt <= 43'h9;
    @(posedge pclk);
    hw_evt <= '0;
    repeat (10) @(posedge pclk);
    rd(8'h30, 32'h1);
    rd(8'h50, 32'hC);
    rd(8'hC0, 32'h0);
    $display("test quiet channel done");
    apb(1'b1, 8'hC0, 32'h3FF);
    err_en <= 1'b1;
    err_addr <= 32'h2000_0100;
    apb(1'b1, 8'h48, 32'h2000_0100);
    apb(1'b1, 8'h44, 32'h0001_0002);
    apb(1'b1, 8'h50, 32'h2);
    repeat (15) @(posedge pclk);
    rd(8'h40, 32'h381);
    rd(8'hC0, 32'h40);
    `CHK(irq, 1'b0)
    apb(1'b1, 8'hC4, 32'h40);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b1)
    apb(1'b1, 8'hC0, 32'h40);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    rd(8'hC0, 32'h0);
    $display("test fetch error done");
    // disable between units: the pending unit lands, then the stop
    slow <= 1'b1;
    apb(1'b1, 8'h64, 32'h0001_0003);
    apb(1'b1, 8'h68, 32'h2000_0200);
    repeat (2) exp_q.push_back({3'h2, memv(32'h2000_0200)});
    apb(1'b1, 8'h70, 32'h2);
    while (exp_q.size() > 1)
      @(posedge pclk);
    apb(1'b1, 8'h60, 32'h80);
    repeat (40) @(posedge pclk);
    rd(8'h60, 32'h280);
    rd(8'h64, 32'h0001_0001);
    rd(8'hC0, 32'h80);
    $display("test stop done");
    wrap_up();
  end
endmodule
`default_nettype wire
